/* design/rstsup_defines.svh */
// rstsup constants: timing, register map, field positions, defaults
`ifndef RSTSUP_DEFINES_SVH
`define RSTSUP_DEFINES_SVH

// timing
`define RSTSUP_CLK_NS        8
`define RSTSUP_POR_NS        150
`define RSTSUP_POR_CYC       ((`RSTSUP_POR_NS+`RSTSUP_CLK_NS-1)/`RSTSUP_CLK_NS)
`define RSTSUP_EXTERNAL_RESET_N_GAP_US   10
`define RSTSUP_BUZZ_ON_CYC   4
`define RSTSUP_WDT_TO_DFLT   1000000
`define RSTSUP_BUZZ_PER_DFLT 1000

// supply trip levels in millivolts
`define RSTSUP_LV_BASE_MV    1700
`define RSTSUP_LV_STEP_MV    250
`define RSTSUP_HV_MV         5750
`define RSTSUP_MV_W          13

// widths
`define RSTSUP_CNT_W         5
`define RSTSUP_WDT_W         24
`define RSTSUP_BUZZ_W        16
`define RSTSUP_STAT_W        10

// register byte offsets
`define RSTSUP_OFS_CTRL      5'h00
`define RSTSUP_OFS_TRIP      5'h04
`define RSTSUP_OFS_WDT       5'h08
`define RSTSUP_OFS_BUZZ      5'h0C
`define RSTSUP_OFS_STAT      5'h10
`define RSTSUP_OFS_LIVE      5'h14

// control bits
`define RSTSUP_C_SWRST       0
`define RSTSUP_C_SWDIS       1
`define RSTSUP_C_WDTEN       2
`define RSTSUP_C_KICK        3
`define RSTSUP_C_ANAOFF      4
`define RSTSUP_C_DLRST       5
`define RSTSUP_C_ALRST       6
`define RSTSUP_C_DLEN        7
`define RSTSUP_C_ALEN        8
`define RSTSUP_C_AHEN        9

// status bits
`define RSTSUP_S_POR         0
`define RSTSUP_S_PRECISE_LOW_VOLTAGE_MONITOR        1
`define RSTSUP_S_EXT         2
`define RSTSUP_S_SW          3
`define RSTSUP_S_WDT         4
`define RSTSUP_S_DLRST       5
`define RSTSUP_S_ALRST       6
`define RSTSUP_S_DLIRQ       7
`define RSTSUP_S_ALIRQ       8
`define RSTSUP_S_AHIRQ       9
`define RSTSUP_STAT_RST      10'h001

`endif

/* design/rstsup_pkg.sv */
// rstsup types: bus request carrier and block state
`include "rstsup_defines.svh"
package rstsup_pkg;

  // avalon-mm request group
  typedef struct packed {
    logic        read;
    logic        write;
    logic [4:0]  address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } rstsup_avs_req_type;

  // configuration restored to its defaults by any device reset
  typedef struct packed {
    logic                      software_reset_dis;
    logic                      ana_off;
    logic                      dl_rst;
    logic                      al_rst;
    logic                      dl_en;
    logic                      al_en;
    logic                      ah_en;
    logic [3:0]                dl_code;
    logic [3:0]                al_code;
    logic [`RSTSUP_WDT_W-1:0]  wdt_to;
    logic [`RSTSUP_BUZZ_W-1:0] buzz_per;
  } rstsup_cfg_type;

  // whole block state
  typedef struct packed {
    logic                      ack;
    logic [31:0]               rdata;
    logic [`RSTSUP_CNT_W-1:0]  cnt;
    logic                      rst_n;
    logic                      boot;
    logic                      software_reset;
    logic                      wdt_en;
    logic [`RSTSUP_WDT_W-1:0]  wdt_cnt;
    logic [`RSTSUP_BUZZ_W-1:0] buzz_cnt;
    logic [3:0]                buzz_on;
    logic [`RSTSUP_STAT_W-1:0] stat;
    rstsup_cfg_type            cfg;
  } rstsup_state_type;

endpackage

/* design/rstsup_top.sv */
// rstsup top: reset source gathering, supply monitors, watchdog, regs
//
// Function
// - a power-on or precise monitor trip requests a device reset; the high-voltage monitor only interrupts.
// - supply monitors can raise a processor interrupt instead.
// - power-on reset pulse lasts at least 150 ns, longer while ramping.
// - after boot the power-on monitor is ignored; precise monitor rules.
// - precise low-voltage trip gives the same reset as power-on.
// - digital precise monitor cannot be turned off; analog follows regulator.
// - precise monitor off in sleep and hibernate, on during buzz windows.
// - low-voltage trip level is 1.70 V plus 250 mV per code step.
// - high-voltage monitor trips above a fixed 5.75 V.
// - each low-voltage monitor may reset instead of interrupting.
// - monitors stay off until power-on ends and are buzzed in sleep.
// - monitor interrupt in sleep first wakes, then is presented.
// - buzz period is software adjustable.
// - reset held while external reset is low; same response as power-on.
// - external reset is active low, pulled up, live in low power modes.
// - writing the software reset bit gives a power-on style reset.
// - a separate bit disables the software reset function.
// - enabled watchdog not restarted within timeout resets the device.
// - watchdog enable is sticky until the next power-on reset.
// - status register records causes and interrupts; power-on resets it to the power-on cause alone.
// - device reset returns the configuration to its reset state; status and watchdog enable are kept.
`timescale 1ns/1ps
module rstsup_top
  import rstsup_pkg::*;
#(
  parameter int unsigned WDT_TO_DFLT   = `RSTSUP_WDT_TO_DFLT,
  parameter int unsigned BUZZ_PER_DFLT = `RSTSUP_BUZZ_PER_DFLT
) (
  // clock and power-on reset
  input  wire logic                     i_clk,
  input  wire logic                     i_nrst,
  // avalon-mm slave
  input  wire rstsup_avs_req_type       i_avs,
  output logic [31:0]                   o_avs_readdata,
  output logic                          o_avs_waitrequest,
  // supply monitor inputs
  input  wire logic                     i_initial_power_on_monitor_trip,
  input  wire logic                     i_precise_low_voltage_monitor_dig_trip,
  input  wire logic                     i_precise_low_voltage_monitor_ana_trip,
  input  wire logic [`RSTSUP_MV_W-1:0]  i_dsup_mv,
  input  wire logic [`RSTSUP_MV_W-1:0]  i_asup_mv,
  // external reset pin and power modes
  input  wire logic                     i_ext_rst_n,
  input  wire logic                     i_sleep,
  input  wire logic                     i_hibernate,
  // reset, interrupt and monitor control
  output logic                          o_dev_rst_n,
  output logic                          o_irq,
  output logic                          o_wake_req,
  output logic                          o_mon_en,
  output logic                          o_precise_low_voltage_monitor_ana_en
);

  // elaboration checks on defaults
  if (WDT_TO_DFLT == 0 || WDT_TO_DFLT >= (1 << `RSTSUP_WDT_W)) begin : g_ck1
    $error("watchdog default timeout out of range");
  end
  if (BUZZ_PER_DFLT == 0 || BUZZ_PER_DFLT >= (1 << `RSTSUP_BUZZ_W)) begin : g_ck2
    $error("buzz period default out of range");
  end

  localparam logic [`RSTSUP_CNT_W-1:0] POR_CYC = `RSTSUP_CNT_W'(`RSTSUP_POR_CYC);
  localparam rstsup_cfg_type CFG_RST = '{
    software_reset_dis: 1'b0, ana_off: 1'b0, dl_rst: 1'b0, al_rst: 1'b0,
    dl_en: 1'b0, al_en: 1'b0, ah_en: 1'b0,
    dl_code: 4'h0, al_code: 4'h0,
    wdt_to: `RSTSUP_WDT_W'(WDT_TO_DFLT),
    buzz_per: `RSTSUP_BUZZ_W'(BUZZ_PER_DFLT)};
  localparam rstsup_state_type ST_RST = '{
    ack: 1'b0, rdata: 32'h0, cnt: POR_CYC, rst_n: 1'b0, boot: 1'b0,
    software_reset: 1'b0, wdt_en: 1'b0, wdt_cnt: '0, buzz_cnt: '0, buzz_on: 4'h0,
    stat: `RSTSUP_STAT_RST, cfg: CFG_RST};

  rstsup_state_type s;
  rstsup_state_type n;

  // byte-lane merge of a write into the old value
  function automatic logic [31:0] merge(input logic [31:0] o,
                                        input logic [31:0] w,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = w[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [`RSTSUP_MV_W-1:0] lv_mv(input logic [3:0] c);
    return `RSTSUP_MV_W'(`RSTSUP_LV_BASE_MV + `RSTSUP_LV_STEP_MV * c);
  endfunction

  logic        acc_req;
  logic        wr_acc;
  logic        awake;
  logic        buzzing;
  logic        mon_on;
  logic        precise_low_voltage_monitor_trip;
  logic        dl_low;
  logic        al_low;
  logic        ah_high;
  logic        initial_power_on_monitor_req;
  logic        wdt_fire;
  logic        lv_rst;
  logic        rst_req;
  logic        irq_pend;
  logic [31:0] ctrl_rd;
  logic [31:0] stat_rd;

  // bus handshake: one wait cycle, answer on the second
  assign acc_req = i_avs.read | i_avs.write;
  assign wr_acc  = i_avs.write & s.ack;
  assign o_avs_waitrequest = acc_req & ~s.ack;
  assign o_avs_readdata    = s.rdata;

  // monitors live when awake or inside a sleep buzz window
  // and never before power-on has finished
  assign awake   = ~i_sleep & ~i_hibernate;
  assign buzzing = s.buzz_on != 4'h0;
  assign mon_on  = s.boot & (awake | (i_sleep & ~i_hibernate & buzzing));

  // digital part gated by mon_on only; analog part follows the regulator
  assign precise_low_voltage_monitor_trip = mon_on & (i_precise_low_voltage_monitor_dig_trip |
                               (i_precise_low_voltage_monitor_ana_trip & ~s.cfg.ana_off));

  assign dl_low = mon_on & s.cfg.dl_en & (i_dsup_mv < lv_mv(s.cfg.dl_code));
  assign al_low = mon_on & s.cfg.al_en & (i_asup_mv < lv_mv(s.cfg.al_code));
  assign ah_high = mon_on & s.cfg.ah_en &
                   (i_asup_mv > `RSTSUP_MV_W'(`RSTSUP_HV_MV));

  // power-on monitor counts only until boot ends
  assign initial_power_on_monitor_req = i_initial_power_on_monitor_trip & ~s.boot;
  assign wdt_fire = s.wdt_en & (s.wdt_cnt >= s.cfg.wdt_to);
  // low-voltage trips routed to reset when so configured
  assign lv_rst = (dl_low & s.cfg.dl_rst) | (al_low & s.cfg.al_rst);

  // every source merges into one request
  // external pin low holds the request; not gated by power mode
  // active low, effective in sleep and hibernate
  assign rst_req = initial_power_on_monitor_req | precise_low_voltage_monitor_trip | ~i_ext_rst_n | s.software_reset |
                   wdt_fire | lv_rst;

  // assert at once, release from the flop
  assign o_dev_rst_n = s.rst_n & ~rst_req;

  // pending monitor irq wakes first, then shows when awake
  assign irq_pend   = |s.stat[`RSTSUP_S_AHIRQ:`RSTSUP_S_DLIRQ];
  assign o_irq      = irq_pend & awake;
  assign o_wake_req = irq_pend & i_sleep;
  assign o_mon_en      = mon_on;
  assign o_precise_low_voltage_monitor_ana_en = mon_on & ~s.cfg.ana_off;

  // readback views
  assign ctrl_rd = {22'h0, s.cfg.ah_en, s.cfg.al_en, s.cfg.dl_en,
                    s.cfg.al_rst, s.cfg.dl_rst, s.cfg.ana_off, 1'b0,
                    s.wdt_en, s.cfg.software_reset_dis, 1'b0};
  assign stat_rd = {22'h0, s.stat};

  // next-state logic
  always_comb begin
    logic [31:0] m;
    logic        kick;
    logic [`RSTSUP_STAT_W-1:0] set;
    logic [`RSTSUP_STAT_W-1:0] clr;
    m    = 32'h0;
    kick = 1'b0;
    clr  = '0;
    set  = '0;
    n    = s;
    n.ack  = acc_req & ~s.ack;
    n.software_reset = 1'b0;

    // read data captured in the wait cycle
    if (acc_req & ~s.ack) begin
      case (i_avs.address)
        `RSTSUP_OFS_CTRL: n.rdata = ctrl_rd;
        `RSTSUP_OFS_TRIP: n.rdata = {24'h0, s.cfg.al_code, s.cfg.dl_code};
        `RSTSUP_OFS_WDT:  n.rdata = 32'(s.cfg.wdt_to);
        `RSTSUP_OFS_BUZZ: n.rdata = 32'(s.cfg.buzz_per);
        `RSTSUP_OFS_STAT: n.rdata = stat_rd;
        `RSTSUP_OFS_LIVE: n.rdata = {27'h0, i_sleep, s.rst_n, mon_on,
                                     buzzing, s.boot};
        default:          n.rdata = 32'h0;
      endcase
    end

    // register writes; unmapped offsets ignored
    if (wr_acc) begin
      case (i_avs.address)
        `RSTSUP_OFS_CTRL: begin
          m = merge(ctrl_rd, i_avs.writedata, i_avs.byteenable);
          // blocked while the disable bit is set
          n.software_reset = m[`RSTSUP_C_SWRST] & ~s.cfg.software_reset_dis;
          n.cfg.software_reset_dis = m[`RSTSUP_C_SWDIS];
          // enable can only be set here
          n.wdt_en = s.wdt_en | m[`RSTSUP_C_WDTEN];
          kick = m[`RSTSUP_C_KICK];
          n.cfg.ana_off = m[`RSTSUP_C_ANAOFF];
          n.cfg.dl_rst = m[`RSTSUP_C_DLRST];
          n.cfg.al_rst = m[`RSTSUP_C_ALRST];
          n.cfg.dl_en  = m[`RSTSUP_C_DLEN];
          n.cfg.al_en  = m[`RSTSUP_C_ALEN];
          n.cfg.ah_en  = m[`RSTSUP_C_AHEN];
        end
        `RSTSUP_OFS_TRIP: begin
          m = merge({24'h0, s.cfg.al_code, s.cfg.dl_code},
                    i_avs.writedata, i_avs.byteenable);
          n.cfg.dl_code = m[3:0];
          n.cfg.al_code = m[7:4];
        end
        `RSTSUP_OFS_WDT: begin
          m = merge(32'(s.cfg.wdt_to), i_avs.writedata, i_avs.byteenable);
          n.cfg.wdt_to = m[`RSTSUP_WDT_W-1:0];
        end
        `RSTSUP_OFS_BUZZ: begin
          m = merge(32'(s.cfg.buzz_per), i_avs.writedata, i_avs.byteenable);
          n.cfg.buzz_per = m[`RSTSUP_BUZZ_W-1:0];
        end
        `RSTSUP_OFS_STAT: begin
          clr = i_avs.writedata[`RSTSUP_STAT_W-1:0] &
                {{2{i_avs.byteenable[1]}}, {8{i_avs.byteenable[0]}}};
        end
        default: begin
          m = 32'h0;
        end
      endcase
    end

    // sticky causes, write one to clear, a new event wins
    set[`RSTSUP_S_POR]   = initial_power_on_monitor_req;
    set[`RSTSUP_S_PRECISE_LOW_VOLTAGE_MONITOR]  = precise_low_voltage_monitor_trip;
    set[`RSTSUP_S_EXT]   = ~i_ext_rst_n;
    set[`RSTSUP_S_SW]    = s.software_reset;
    set[`RSTSUP_S_WDT]   = wdt_fire;
    set[`RSTSUP_S_DLRST] = dl_low & s.cfg.dl_rst;
    set[`RSTSUP_S_ALRST] = al_low & s.cfg.al_rst;
    set[`RSTSUP_S_DLIRQ] = dl_low & ~s.cfg.dl_rst;
    set[`RSTSUP_S_ALIRQ] = al_low & ~s.cfg.al_rst;
    set[`RSTSUP_S_AHIRQ] = ah_high;
    n.stat = (s.stat & ~clr) | set;

    // stretch counter restarts while any request stands
    // every source shares the same stretch
    if (rst_req) begin
      n.cnt = POR_CYC;
    end else if (s.cnt != '0) begin
      n.cnt = s.cnt - 1'b1;
    end
    // release only on a clock edge
    n.rst_n = ~rst_req & (n.cnt == '0);
    // boot ends at the first release
    n.boot = s.boot | s.rst_n;

    // watchdog counts while enabled, restarted by a kick
    if (~s.wdt_en | kick | ~s.rst_n) begin
      n.wdt_cnt = '0;
    end else if (~wdt_fire) begin
      n.wdt_cnt = s.wdt_cnt + 1'b1;
    end

    // periodic buzz windows in sleep only
    if (i_sleep & ~i_hibernate) begin
      if (buzzing) begin
        n.buzz_on = s.buzz_on - 4'h1;
      end
      if (s.buzz_cnt == '0) begin
        n.buzz_cnt = s.cfg.buzz_per;
        n.buzz_on  = 4'(`RSTSUP_BUZZ_ON_CYC);
      end else begin
        n.buzz_cnt = s.buzz_cnt - 1'b1;
      end
    end else begin
      n.buzz_cnt = s.cfg.buzz_per;
      n.buzz_on  = 4'h0;
    end

    // device reset restores the configuration
    // status and watchdog enable survive; only power-on resets them (status to the power-on bit)
    if (~s.rst_n) begin
      n.cfg = CFG_RST;
    end
  end

  // state register; power-on reset loads constants only
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s <= ST_RST;
    end else begin
      s <= n;
    end
  end

  // helper: length of the current low phase of the reset output
  logic [7:0] lo_cnt;
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      lo_cnt <= 8'h00;
    end else if (o_dev_rst_n) begin
      lo_cnt <= 8'h00;
    end else if (lo_cnt != 8'hFF) begin
      lo_cnt <= lo_cnt + 8'h01;
    end
  end

  localparam int POR_CYC_I = `RSTSUP_POR_CYC;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  a_por_stretch: assert property (
    $rose(o_dev_rst_n) |-> lo_cnt >= POR_CYC_I)
    else $error("reset pulse shorter than minimum");
  a_precise_low_voltage_monitor_same: assert property (
    precise_low_voltage_monitor_trip |=> !o_dev_rst_n ##0 s.cnt == POR_CYC)
    else $error("precise trip did not restart stretch");
  a_ext_hold: assert property (
    !i_ext_rst_n |-> !o_dev_rst_n)
    else $error("external reset low but device out of reset");
  a_sw_reset: assert property (
    wr_acc && i_avs.address == `RSTSUP_OFS_CTRL &&
    i_avs.byteenable[0] && i_avs.writedata[`RSTSUP_C_SWRST] &&
    !s.cfg.software_reset_dis |=> !o_dev_rst_n [*2])
    else $error("software reset not taken");
  a_sw_disable: assert property (
    s.cfg.software_reset_dis |=> !s.software_reset)
    else $error("software reset fired while disabled");
  a_wdt_expire: assert property (
    s.wdt_en && s.wdt_cnt >= s.cfg.wdt_to |-> !o_dev_rst_n ##1 !s.rst_n)
    else $error("watchdog expiry did not reset");
  a_wdt_sticky: assert property (
    s.wdt_en |=> s.wdt_en)
    else $error("watchdog enable cleared");
  a_hv_fixed: assert property (
    mon_on && s.cfg.ah_en && i_asup_mv > 13'h1676 |=>
    s.stat[`RSTSUP_S_AHIRQ])
    else $error("high voltage not flagged");
  a_irq_after_wake: assert property (
    i_sleep |-> !o_irq ##0 (irq_pend == o_wake_req))
    else $error("interrupt presented before wake");
  a_mon_gated: assert property (
    !s.boot || i_hibernate |-> !mon_on)
    else $error("monitor active before boot or in hibernate");
  a_cfg_cleared: assert property (
    !s.rst_n ##1 !s.rst_n |-> s.cfg == CFG_RST)
    else $error("config not restored during reset");
  a_bus_answer: assert property (
    acc_req && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("bus answer late");
  // set must beat a clear written in the same cycle
  a_ext_flag: assert property (
    !i_ext_rst_n |=> s.stat[`RSTSUP_S_EXT])
    else $error("external reset cause not recorded");
  a_wdt_clear: assert property (
    !s.rst_n |=> s.wdt_cnt == '0)
    else $error("watchdog count kept through reset");

  c_sw_reset:  cover property (s.software_reset ##[1:30] $rose(o_dev_rst_n));
  c_wdt_reset: cover property (wdt_fire ##[1:30] $rose(o_dev_rst_n));
  c_ext_reset: cover property ($fell(i_ext_rst_n) ##[1:100] $rose(o_dev_rst_n));
  c_buzz_wake: cover property (i_sleep && buzzing ##1 o_wake_req);

endmodule

/* testbench/reset_supervisor_test.sv */
// self-checking testbench for the reset supervisor
`timescale 1ns/1ps
`include "rstsup_defines.svh"
module reset_supervisor_test;
  import rstsup_pkg::*;
  logic               clk;
  logic               nrst;
  logic               initial_power_on_monitor;
  logic               pdig;
  logic               pana;
  logic               hib;
  logic               slp;
  logic               go;
  logic               ext_n;
  logic               busy;
  logic [12:0]        dmv;
  logic [12:0]        amv;
  rstsup_avs_req_type avs;
  logic [31:0]        rdata;
  logic               wreq;
  logic               dev_n;
  logic               irq;
  logic               wake;
  logic               mon;
  logic               pana_en;
  logic [31:0]        q;
  int                 n;
  int                 fails = 0;
  int                 n_compared = 0;

  rstsup_top #(.WDT_TO_DFLT(50), .BUZZ_PER_DFLT(20)) dut_u (
    .i_clk(clk), .i_nrst(nrst), .i_avs(avs), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wreq), .i_initial_power_on_monitor_trip(initial_power_on_monitor), .i_precise_low_voltage_monitor_dig_trip(pdig),
    .i_precise_low_voltage_monitor_ana_trip(pana), .i_dsup_mv(dmv), .i_asup_mv(amv),
    .i_ext_rst_n(ext_n), .i_sleep(slp), .i_hibernate(hib),
    .o_dev_rst_n(dev_n), .o_irq(irq), .o_wake_req(wake), .o_mon_en(mon),
    .o_precise_low_voltage_monitor_ana_en(pana_en));

  rstsup_ext_drv ext_u (.i_clk(clk), .i_go(go), .i_len(8'h05),
    .o_ext_rst_n(ext_n), .o_busy(busy));

  // clock at 125 MHz
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one avalon access; held until waitrequest is low at a rising edge
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int t;
    t = 0;
    avs <= '{read: !w, write: w, address: a, writedata: d, byteenable: 4'hF};
    do begin
      @(posedge clk);
      t++;
    end while (wreq !== 1'b0 && t < 20);
    // taken edge: read data stands here, release right after it
    q = rdata;
    avs <= '0;
    chk("bus answer", 32'h0, {31'h0, t >= 20});
    @(posedge clk);
  endtask

  // wait for the device reset to reach a level; n counts edges
  task automatic wait_dev(input logic lv, input int mx);
    n = 0;
    #1;
    while (dev_n !== lv && n < mx) begin
      @(posedge clk);
      #1;
      n++;
    end
    @(posedge clk);
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask

  // status bit check, then clear all status bits
  task automatic stat_is(input string nm, input int b);
    bus(1'b0, `RSTSUP_OFS_STAT, 32'h0);
    chk(nm, 32'h1, {31'h0, q[b]});
    bus(1'b1, `RSTSUP_OFS_STAT, 32'h3FF);
  endtask

  task automatic t_por;
    nrst <= 1'b1;
    cyc(30);
    chk("por stretch", 32'h0, {31'h0, dev_n});
    initial_power_on_monitor <= 1'b0;
    wait_dev(1'b1, 100);
    chk("por width", 32'h1, {31'h0, n >= `RSTSUP_POR_CYC});
    stat_is("stat por", `RSTSUP_S_POR);
    initial_power_on_monitor <= 1'b1;
    cyc(3);
    chk("initial_power_on_monitor ignored", 32'h1, {31'h0, dev_n});
    initial_power_on_monitor <= 1'b0;
    bus(1'b0, 5'h1C, 32'h0);
    chk("unmapped read", 32'h0, q);
  endtask

  task automatic t_sw;
    bus(1'b1, `RSTSUP_OFS_CTRL, 32'h010);
    chk("ana off", 32'h0, {31'h0, pana_en});
    chk("dig mon on", 32'h1, {31'h0, mon});
    pana <= 1'b1;
    cyc(3);
    chk("ana trip ignored", 32'h1, {31'h0, dev_n});
    pana <= 1'b0;
    bus(1'b1, `RSTSUP_OFS_CTRL, 32'h002);
    bus(1'b1, `RSTSUP_OFS_CTRL, 32'h001);
    chk("sw disabled", 32'h1, {31'h0, dev_n});
    bus(1'b1, `RSTSUP_OFS_CTRL, 32'h000);
    bus(1'b1, `RSTSUP_OFS_CTRL, 32'h001);
    wait_dev(1'b1, 100);
    chk("sw reset len", 32'h1, {31'h0, n >= 19});
    bus(1'b0, `RSTSUP_OFS_CTRL, 32'h0);
    chk("ctrl cleared", 32'h0, q);
    stat_is("stat sw", `RSTSUP_S_SW);
    pdig <= 1'b1;
    cyc(3);
    pdig <= 1'b0;
    wait_dev(1'b1, 100);
    chk("precise_low_voltage_monitor len", 32'h1, {31'h0, n >= 19});
    stat_is("stat precise_low_voltage_monitor", `RSTSUP_S_PRECISE_LOW_VOLTAGE_MONITOR);
  endtask

  // every trip code at its boundary, then high-voltage and reset mode
  task automatic t_mon;
    bus(1'b1, `RSTSUP_OFS_CTRL, 32'h380);
    for (int c = 0; c < 16; c++) begin
      bus(1'b1, `RSTSUP_OFS_TRIP, 32'(c));
      dmv <= 13'(1700 + 250 * c);
      cyc(3);
      chk("at trip level", 32'h0, {31'h0, irq});
      dmv <= 13'(1699 + 250 * c);
      cyc(3);
      chk("below trip", 32'h1, {31'h0, irq});
      // idle above the highest trip level so no code trips at rest
      dmv <= 13'h1600;
      stat_is("stat dl irq", `RSTSUP_S_DLIRQ);
    end
    amv <= 13'h1676;
    cyc(3);
    chk("hv at level", 32'h0, {31'h0, irq});
    amv <= 13'h1677;
    cyc(3);
    chk("hv above", 32'h1, {31'h0, irq});
    amv <= 13'h0CE4;
    stat_is("stat hv", `RSTSUP_S_AHIRQ);
    bus(1'b1, `RSTSUP_OFS_CTRL, 32'h0A0);
    dmv <= 13'h0640;
    wait_dev(1'b0, 10);
    chk("lv reset", 32'h0, {31'h0, dev_n});
    dmv <= 13'h0CE4;
    wait_dev(1'b1, 100);
    stat_is("stat dl rst", `RSTSUP_S_DLRST);
  endtask

  task automatic t_sleep;
    bus(1'b1, `RSTSUP_OFS_CTRL, 32'h080);
    bus(1'b1, `RSTSUP_OFS_TRIP, 32'h0);
    bus(1'b1, `RSTSUP_OFS_BUZZ, 32'd10);
    slp <= 1'b1;
    cyc(3);
    chk("mon off asleep", 32'h0, {31'h0, mon});
    n = 0;
    while (mon !== 1'b1 && n < 40) begin
      cyc(1);
      n++;
    end
    chk("buzz window", 32'h1, {31'h0, mon});
    // first window opens period+1 cycles into sleep
    chk("buzz period", 32'd9, 32'(n));
    dmv <= 13'h0640;
    n = 0;
    while (wake !== 1'b1 && n < 80) begin
      cyc(1);
      n++;
    end
    chk("wake req", 32'h1, {31'h0, wake});
    chk("irq held asleep", 32'h0, {31'h0, irq});
    hib <= 1'b1;
    go <= 1'b1;
    cyc(1);
    go <= 1'b0;
    wait_dev(1'b0, 10);
    chk("ext in hibernate", 32'h0, {31'h0, dev_n});
    chk("mon off hibernate", 32'h0, {31'h0, mon});
    wait_dev(1'b1, 100);
    chk("ext hold", 32'h1, {31'h0, n >= 5});
    chk("ext gap busy", 32'h1, {31'h0, busy});
    slp <= 1'b0;
    hib <= 1'b0;
    dmv <= 13'h0CE4;
    stat_is("stat ext", `RSTSUP_S_EXT);
  endtask

  task automatic t_wdt;
    bus(1'b1, `RSTSUP_OFS_CTRL, 32'h004);
    // kicks well inside the timeout keep the device running
    repeat (3) begin
      cyc(30);
      bus(1'b1, `RSTSUP_OFS_CTRL, 32'h00C);
    end
    chk("wdt kicked", 32'h1, {31'h0, dev_n});
    wait_dev(1'b0, 200);
    chk("wdt fired", 32'h0, {31'h0, dev_n});
    wait_dev(1'b1, 100);
    bus(1'b1, `RSTSUP_OFS_CTRL, 32'h000);
    bus(1'b0, `RSTSUP_OFS_CTRL, 32'h0);
    chk("wdt sticky", 32'h1, {31'h0, q[`RSTSUP_C_WDTEN]});
    stat_is("stat wdt", `RSTSUP_S_WDT);
    bus(1'b0, `RSTSUP_OFS_WDT, 32'h0);
    chk("wdt timeout", 32'd50, q);
    // second power-on clears the sticky enable and leaves only the power-on status bit
    nrst <= 1'b0;
    cyc(2);
    nrst <= 1'b1;
    wait_dev(1'b1, 100);
    chk("por again", 32'h1, {31'h0, n >= `RSTSUP_POR_CYC});
    bus(1'b0, `RSTSUP_OFS_CTRL, 32'h0);
    chk("wdt off after por", 32'h0, {31'h0, q[`RSTSUP_C_WDTEN]});
    bus(1'b0, `RSTSUP_OFS_STAT, 32'h0);
    chk("stat after por", 32'h1, q);
  endtask

  task automatic finish_test;
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // hang guard well beyond the expected run length
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    finish_test();
  end

  // main sequence: power-on with a slow supply, then each source
  initial begin
    nrst = 1'b0;
    initial_power_on_monitor = 1'b1;
    pdig = 1'b0;
    pana = 1'b0;
    hib = 1'b0;
    slp = 1'b0;
    go = 1'b0;
    dmv = 13'h0CE4;
    amv = 13'h0CE4;
    avs = '0;
    cyc(2);
    t_por();
    t_sw();
    t_mon();
    t_sleep();
    t_wdt();
    finish_test();
  end
endmodule

/* testbench/rstsup_ext_drv.sv */
// external reset driver model: pulse on request, pull-up level when idle
`timescale 1ns/1ps
module rstsup_ext_drv #(
  parameter int GAP_CYC = 1250
) (
  // clock
  input  wire logic       i_clk,
  // pulse request and its length in cycles
  input  wire logic       i_go,
  input  wire logic [7:0] i_len,
  // pin and status
  output logic            o_ext_rst_n,
  output logic            o_busy
);
  int hold_q = 0;
  int gap_q = 0;

  initial begin
    o_ext_rst_n = 1'b1;
  end

  always @(posedge i_clk) begin
    if (hold_q > 0) begin
      hold_q <= hold_q - 1;
      if (hold_q == 1) begin
        o_ext_rst_n <= 1'b1;
        gap_q       <= GAP_CYC;
      end
    end else if (gap_q > 0) begin
      gap_q <= gap_q - 1;
    end else if (i_go) begin
      o_ext_rst_n <= 1'b0;
      hold_q      <= int'(i_len);
    end
  end

  // a new request is ignored until the gap has run out
  assign o_busy = (hold_q > 0) || (gap_q > 0);
endmodule
